// ### src/temp_readout_pkg.sv
// Package with constants and types for the remote temperature readout block
package temp_readout_pkg;

  // Conversion timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned PERIOD_FAST_MS  = 500;
  localparam int unsigned PERIOD_SLOW_MS  = 8000;
  localparam int unsigned CONV_TIME_MS    = 320;
  localparam int unsigned PERIOD_FAST_CYC = (CLK_HZ / 1000) * PERIOD_FAST_MS;
  localparam int unsigned PERIOD_SLOW_CYC = (CLK_HZ / 1000) * PERIOD_SLOW_MS;
  localparam int unsigned CONV_TIME_CYC   = (CLK_HZ / 1000) * CONV_TIME_MS;
  localparam int unsigned TIMER_W         = 28;

  // Frame layout
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned TEMP_BITS    = 13;
  localparam int unsigned BIT_CNT_W    = 5;
  localparam logic [4:0]  BIT_LOW_IDX  = 5'h02;
  localparam logic [4:0]  BIT_HIZ_IDX  = 5'h01;
  localparam logic [12:0] TEMP_RESET   = 13'h0000;
  localparam logic [12:0] TEMP_MAX     = 13'h0910;

  // Serial pin bundle towards the master
  typedef struct packed {
    logic data;
    logic oe_n;
  } sdo_t;

  // Result handed from the sequencer to the shifter
  typedef struct packed {
    logic        valid;
    logic [12:0] temp;
  } result_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_WAIT
  } conv_state_t;

endpackage

// ### src/pin_sync.sv
// Two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ns
module pin_sync
  import temp_readout_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta;
  logic stable;
  logic last;

  // First flop feeds only the second one
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta   <= RESET_VAL;
      stable <= RESET_VAL;
      last   <= RESET_VAL;
    end else begin
      meta   <= i_pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign o_level = stable;
  assign o_rise  = stable & ~last;
  assign o_fall  = ~stable & last;

endmodule

// ### src/temp_shifter.sv
// Output shift register that serialises one 16-bit temperature frame
`timescale 1ns/1ns
module temp_shifter
  import temp_readout_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_load,
  input  wire logic        i_release,
  input  wire logic        i_sck_fall,
  input  wire logic [12:0] i_temp,
  output sdo_t             o_sdo
);

  logic [FRAME_BITS-1:0] shreg;
  logic [BIT_CNT_W-1:0]  bits_left;
  logic                  active;

  // Load on select fall, shift on each clock fall, float on select rise
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      shreg     <= '0;
      bits_left <= '0;
      active    <= 1'b0;
    end else if (i_release) begin
      active    <= 1'b0;
      bits_left <= '0;
    end else if (i_load) begin
      shreg     <= {i_temp, 3'h0};
      bits_left <= BIT_CNT_W'(FRAME_BITS);
      active    <= 1'b1;
    end else if (active && i_sck_fall && bits_left != '0) begin
      shreg     <= {shreg[FRAME_BITS-2:0], 1'b0};
      bits_left <= bits_left - 5'h01;
    end
  end

  // Bit index of the bit now on the line is bits_left minus one
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sdo <= '{data: 1'b0, oe_n: 1'b1};
    end else begin
      o_sdo.data <= shreg[FRAME_BITS-1];
      // Last two bits and idle time float; hi-Z once 16 bits have passed too
      o_sdo.oe_n <= ~(active && (bits_left > BIT_LOW_IDX));
    end
  end

endmodule

// ### src/temp_readout.sv
// Conversion sequencer and serial readout of a remote-diode temperature sensor
// Function
// - Free-running conversions start every 0.5 s (fast) or 8 s (slow).
// - Reads always return the last completed result, never a partial one.
// - Falling chip select aborts any conversion in progress.
// - Rising chip select resets the serial interface and starts a conversion.
// - Chip select low means idle: no conversion, serial readout still works.
// - During reset the interface is off and result holds 0 degrees.
// - Falling chip select copies the result into the shift register.
// - Frame goes out MSB first, advancing on each serial clock fall.
// - A frame is 16 serial clocks carrying D15 down to D0.
// - D15 to D3 hold a 13-bit two's-complement value, 0.0625 degree LSB.
// - D2 is driven low; D1 and D0 are high impedance.
// - Encoding covers up to +145 degrees without overflow.
// - Data output enabled after select falls, floats after select rises.
`timescale 1ns/1ns
module temp_readout
  import temp_readout_pkg::*;
#(
  parameter bit          FAST_VARIANT = 1'b1,
  parameter int unsigned PERIOD_FAST  = PERIOD_FAST_CYC,
  parameter int unsigned PERIOD_SLOW  = PERIOD_SLOW_CYC,
  parameter int unsigned CONV_TIME    = CONV_TIME_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic [12:0] i_adc_temp,
  output logic             o_sdo,
  output logic             o_sdo_oe_n,
  output logic             o_converting
);

  localparam logic [TIMER_W-1:0] PERIOD = FAST_VARIANT ? TIMER_W'(PERIOD_FAST) : TIMER_W'(PERIOD_SLOW);
  localparam logic [TIMER_W-1:0] CONV   = TIMER_W'(CONV_TIME);

  logic              cs_level;
  logic              cs_rise;
  logic              cs_fall;
  logic              sck_fall;
  conv_state_t       state;
  logic [TIMER_W-1:0] timer;
  logic [12:0]       result;
  sdo_t              sdo;

  // Select idles high so reset release looks like a deselected bus
  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_pin     (i_cs_n),
    .o_level   (cs_level),
    .o_rise    (cs_rise),
    .o_fall    (cs_fall)
  );

  // Serial clock is only sampled; 400 ns link period gives 8 samples per cycle
  // Only the falling edge matters here: the master samples late in the high phase
  pin_sync #(
    .RESET_VAL (1'b0)
  ) u_sck_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_pin     (i_sck),
    .o_level   (),
    .o_rise    (),
    .o_fall    (sck_fall)
  );

  // Conversion sequencer: run phase then wait for the rest of the period
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= CONV_RUN;
      timer <= '0;
    end else if (cs_fall) begin
      state <= CONV_IDLE;
      timer <= '0;
    end else if (cs_rise) begin
      state <= CONV_RUN;
      timer <= '0;
    end else begin
      unique case (state)
        CONV_IDLE: begin
          timer <= '0;
        end
        CONV_RUN: begin
          // Completion needs the full conversion time with select high
          if (timer >= CONV - 1'b1) begin
            state <= CONV_WAIT;
          end
          timer <= timer + 1'b1;
        end
        CONV_WAIT: begin
          // Period restarts from the start of the previous conversion
          if (timer >= PERIOD - 1'b1) begin
            state <= CONV_RUN;
            timer <= '0;
          end else begin
            timer <= timer + 1'b1;
          end
        end
      endcase
    end
  end

  // Result updates only on completion, so a read never sees a partial value
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      result <= TEMP_RESET;
    end else if (state == CONV_RUN && timer >= CONV - 1'b1 && !cs_fall && !cs_rise) begin
      // 13-bit signed field holds +145 degrees (0x910) with room to spare
      result <= i_adc_temp;
    end
  end

  // Status of the converter for power control outside
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_converting <= 1'b0;
    end else begin
      o_converting <= (state == CONV_RUN) && cs_level;
    end
  end

  // Frame load on select fall, interface reset on select rise; no data input
  temp_shifter u_shifter (
    .i_clk_sys  (i_clk_sys),
    .i_resetn   (i_resetn),
    .i_load     (cs_fall),
    .i_release  (cs_rise),
    .i_sck_fall (sck_fall),
    .i_temp     (result),
    .o_sdo      (sdo)
  );

  // Registered copy to the pins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sdo      <= 1'b0;
      o_sdo_oe_n <= 1'b1;
    end else begin
      o_sdo      <= sdo.data;
      o_sdo_oe_n <= sdo.oe_n;
    end
  end

endmodule

// ### dv/temp_readout_properties.sv
// Port checks for the temperature readout block
`timescale 1ns/1ns
module temp_readout_properties #(
  parameter bit          FAST_VARIANT = 1'b1,
  parameter int unsigned PERIOD_FAST  = 200,
  parameter int unsigned PERIOD_SLOW  = 400,
  parameter int unsigned CONV_TIME    = 50
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic o_sdo_oe_n,
  input wire logic o_converting
);
  localparam int unsigned PER = FAST_VARIANT ? PERIOD_FAST : PERIOD_SLOW;
  int unsigned run_len;
  int unsigned gap;
  logic        cs_seen;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Run length, start gap; select activity excuses a start from the period check
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      run_len <= 0;
      gap     <= 0;
      cs_seen <= 1'b1;
    end else begin
      run_len <= o_converting ? run_len + 1 : 0;
      gap     <= $rose(o_converting) ? 1 : gap + 1;
      if (!i_cs_n)
        cs_seen <= 1'b1;
      else if ($rose(o_converting))
        cs_seen <= 1'b0;
    end
  end
  chk_reset_float: assert property ($rose(i_resetn) |-> o_sdo_oe_n && !o_converting)
    else $error("busy at reset release");
  chk_auto_start: assert property ($rose(i_resetn) |-> ##[1:4] o_converting)
    else $error("no start after reset");
  chk_idle_quiet: assert property (!i_cs_n [*6] |-> !o_converting)
    else $error("converting while selected");
  chk_drive_select: assert property ($fell(i_cs_n) |-> ##[1:8] !o_sdo_oe_n)
    else $error("data not driven");
  chk_float_idle: assert property (i_cs_n [*8] |-> o_sdo_oe_n)
    else $error("data driven while deselected");
  chk_restart_conv: assert property ($rose(i_cs_n) |-> ##[1:8] o_converting)
    else $error("no restart on deselect");
  chk_conv_time: assert property ($fell(o_converting) && i_cs_n |-> run_len inside {[CONV_TIME-1:CONV_TIME+1]})
    else $error("conversion length wrong");
  chk_free_period: assert property ($rose(o_converting) && !cs_seen |-> gap inside {[PER-1:PER+1]})
    else $error("free-running period wrong");
endmodule
bind temp_readout temp_readout_properties #(.FAST_VARIANT(FAST_VARIANT), .PERIOD_FAST(PERIOD_FAST),
  .PERIOD_SLOW(PERIOD_SLOW), .CONV_TIME(CONV_TIME)) chk (.i_clk_sys, .i_resetn, .i_cs_n, .o_sdo_oe_n, .o_converting);

// ### dv/spi_master_model.sv
// Bit-banging serial master that reads frames from the sensor
`timescale 1ns/1ns
module spi_master_model (
  input  wire logic   i_clk_sys,
  input  wire logic   i_sdo,
  input  wire logic   i_sdo_oe_n,
  output logic        o_cs_n,
  output logic        o_sck,
  output logic [15:0] o_frame,
  output logic        o_done
);
  // Select high and clock parked low outside frames
  initial begin
    o_cs_n  = 1'b1;
    o_sck   = 1'b0;
    o_frame = '0;
    o_done  = 1'b0;
  end
  // 400 ns clock; bits taken late in the high phase, as the sensor answers through a synchroniser
  task automatic read();
    o_cs_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    for (int i = 15; i >= 0; i--) begin
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      o_frame[i] = i_sdo_oe_n ? 1'bz : i_sdo;
      o_sck = 1'b0;
      repeat (4) @(negedge i_clk_sys);
    end
    o_cs_n = 1'b1;
    o_done = 1'b1;
    @(negedge i_clk_sys);
    o_done = 1'b0;
  endtask
endmodule

// ### dv/tb_temp_readout.sv
// Self-checking bench for the temperature readout block
`timescale 1ns/1ns
module tb_temp_readout
  import temp_readout_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_resetn = 1'b0;
  logic [12:0] adc = 13'h0000;
  logic        cs_n, sck, sdo, sdo_oe_n, done;
  logic [15:0] frame;
  logic [15:0] exp_q[$];
  logic [12:0] tbl[$] = '{13'h0960, 13'h07D0, 13'h0190, 13'h0001, 13'h1FFF, 13'h1E70, 13'h1C90, TEMP_MAX};
  int          bad_count = 0;
  int          samples_checked = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  temp_readout #(.FAST_VARIANT(1'b1), .PERIOD_FAST(200), .PERIOD_SLOW(400), .CONV_TIME(50)) DUT (
    .i_clk_sys, .i_resetn, .i_cs_n(cs_n), .i_sck(sck), .i_adc_temp(adc),
    .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_converting());
  spi_master_model master (.i_clk_sys, .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_cs_n(cs_n), .o_sck(sck),
    .o_frame(frame), .o_done(done));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Note the frame expected: code, a low bit, two floating bits
  task automatic expect_read(input logic [12:0] t);
    exp_q.push_back({t, 1'b0, 2'bzz});
    master.read();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Each finished frame meets the oldest note; an empty queue cannot match
  always @(posedge done) begin
    check("frame", frame, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
  end
  initial begin
    void'($urandom(32'h39d9));
    wait_cyc(10);
    check("oe_n in reset", {15'h0000, sdo_oe_n}, 16'h0001);
    i_resetn = 1'b1;
    adc = 13'h0555;
    wait_cyc(3);
    expect_read(13'h0000);
    // Selecting mid-conversion must leave the old result in place
    wait_cyc(20);
    expect_read(13'h0000);
    wait_cyc(20);
    expect_read(13'h0000);
    repeat (4) tbl.push_back(13'($urandom));
    foreach (tbl[i]) begin
      adc = tbl[i];
      wait_cyc(70);
      expect_read(tbl[i]);
    end
    // A later free-running conversion picks up a new code with no select activity
    wait_cyc(70);
    adc = 13'h1F00;
    wait_cyc(200);
    expect_read(13'h1F00);
    wait_cyc(20);
    conclude();
  end
  // Watchdog against a hang
  initial begin
    wait_cyc(20000);
    bad_count++;
    conclude();
  end
endmodule
